/* verilog/ist_pkg.sv */
// constants and types shared by the millisecond timer set
// assumes a single 40 MHz clock and a millisecond time base made from it
package ist_pkg;

  typedef enum logic [1:0] {
    MODE_PULSE,
    MODE_ON_DELAY,
    MODE_OFF_DELAY,
    MODE_RETENTIVE
  } ist_mode_t;

  localparam int TIME_W         = 32;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int NUM_CHANNELS   = 8;

  localparam logic [31:0] RST_TIME = 32'h0000_0000;
  localparam logic        RST_BIT  = 1'b0;

endpackage

/* verilog/ist_timer_set.sv */
// bank of independent millisecond timers, one operation per clock
// assumes the controlling logic drives requests synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none

module ist_timer_set
  import ist_pkg::*;
#(
  parameter int NUM_CH    = NUM_CHANNELS,
  parameter int TICK_DIV  = TICK_CYCLES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clrAll,
  input  wire logic                      evalValid,
  input  wire logic [$clog2(NUM_CH)-1:0] evalCh,
  input  wire ist_mode_t                 evalMode,
  input  wire logic                      evalIn,
  input  wire logic                      evalClr,
  input  wire logic                      readValid,
  input  wire logic [$clog2(NUM_CH)-1:0] readCh,
  input  wire logic                      loadStb,
  input  wire logic [$clog2(NUM_CH)-1:0] loadCh,
  input  wire logic signed [TIME_W-1:0]  loadVal,
  input  wire logic                      clrStb,
  input  wire logic [$clog2(NUM_CH)-1:0] clrCh,
  output logic                           outValid,
  output logic [$clog2(NUM_CH)-1:0]      outCh,
  output logic                           qOut,
  output logic [TIME_W-1:0]              etOut,
  output logic                           loadPass,
  output logic                           clrPass,
  output logic [NUM_CH-1:0]              chDone,
  output logic                           msTick
);

  localparam int CW = $clog2(NUM_CH);

  if (NUM_CH < 2 || TICK_DIV < 1 || TIME_W != 32) begin : g_bad_params
    $error("ist_timer_set: unsupported parameter values");
  end

  // millisecond time base
  logic [31:0]       divCntQ;
  logic [31:0]       divCntD;
  logic              tickQ;
  logic              tickD;
  logic [TIME_W-1:0] msNowQ;
  logic [TIME_W-1:0] msNowD;

  always_comb begin
    divCntD = divCntQ + 32'h0000_0001;
    tickD   = 1'b0;
    msNowD  = msNowQ;
    if (divCntQ >= 32'(TICK_DIV - 1)) begin
      divCntD = 32'h0000_0000;
      tickD   = 1'b1;
    end
    if (tickQ) begin
      msNowD = msNowQ + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCntQ <= 32'h0000_0000;
      tickQ   <= 1'b0;
      msNowQ  <= RST_TIME;
    end else begin
      divCntQ <= divCntD;
      tickQ   <= tickD;
      msNowQ  <= msNowD;
    end
  end

  // per-channel state records
  logic signed [TIME_W-1:0] presetQ [NUM_CH];
  logic signed [TIME_W-1:0] presetD [NUM_CH];
  logic [TIME_W-1:0]        etQ     [NUM_CH];
  logic [TIME_W-1:0]        etD     [NUM_CH];
  logic [TIME_W-1:0]        aptQ    [NUM_CH];
  logic [TIME_W-1:0]        aptD    [NUM_CH];
  logic [TIME_W-1:0]        stampQ  [NUM_CH];
  logic [TIME_W-1:0]        stampD  [NUM_CH];
  ist_mode_t                modeQ   [NUM_CH];
  ist_mode_t                modeD   [NUM_CH];
  logic [NUM_CH-1:0]        qQ;
  logic [NUM_CH-1:0]        qD;
  logic [NUM_CH-1:0]        runQ;
  logic [NUM_CH-1:0]        runD;
  logic [NUM_CH-1:0]        inPrevQ;
  logic [NUM_CH-1:0]        inPrevD;

  // operation selection: evaluation wins over a plain read
  logic          opGo;
  logic [CW-1:0] opCh;
  logic          opIn;
  logic          opClr;
  ist_mode_t     opMode;

  assign opGo   = evalValid | readValid;
  assign opCh   = evalValid ? evalCh : readCh;
  assign opIn   = evalValid ? evalIn : inPrevQ[opCh];
  assign opClr  = evalValid & evalClr;
  assign opMode = evalValid ? evalMode : modeQ[opCh];

  logic [TIME_W-1:0] ptEff;
  logic [TIME_W-1:0] dt;
  logic [TIME_W:0]   sum;
  logic [TIME_W-1:0] etAdv;
  logic [TIME_W-1:0] curEt;
  logic [TIME_W-1:0] curApt;
  logic              curQ;
  logic              curRun;
  logic              rise;
  logic              fall;

  always_comb begin
    presetD = presetQ;
    etD     = etQ;
    aptD    = aptQ;
    stampD  = stampQ;
    modeD   = modeQ;
    qD      = qQ;
    runD    = runQ;
    inPrevD = inPrevQ;
    ptEff   = presetQ[opCh][TIME_W-1] ? RST_TIME : presetQ[opCh];
    dt      = msNowQ - stampQ[opCh];
    sum     = {1'b0, etQ[opCh]} + {1'b0, dt};
    etAdv   = (sum > {1'b0, aptQ[opCh]}) ? aptQ[opCh]
                                         : sum[TIME_W-1:0];
    curEt   = etQ[opCh];
    curApt  = aptQ[opCh];
    curQ    = qQ[opCh];
    curRun  = runQ[opCh];
    rise    = opIn & ~inPrevQ[opCh];
    fall    = ~opIn & inPrevQ[opCh];
    if (opGo) begin
      unique case (opMode)
        MODE_PULSE: begin
          if (runQ[opCh]) begin
            curEt = etAdv;
            if (etAdv >= curApt) begin
              curRun = 1'b0;
              curQ   = 1'b0;
            end
          end else if (rise) begin
            curApt = ptEff;
            curEt  = RST_TIME;
            curRun = (ptEff != RST_TIME);
            curQ   = (ptEff != RST_TIME);
          end else if (!opIn) begin
            curEt = RST_TIME;
          end
        end
        MODE_ON_DELAY: begin
          if (!opIn) begin
            curEt  = RST_TIME;
            curRun = 1'b0;
            curQ   = 1'b0;
          end else if (rise) begin
            curApt = ptEff;
            curEt  = RST_TIME;
            curRun = (ptEff != RST_TIME);
            curQ   = (ptEff == RST_TIME);
          end else if (runQ[opCh]) begin
            curEt = etAdv;
            if (etAdv >= curApt) begin
              curRun = 1'b0;
              curQ   = 1'b1;
            end
          end
        end
        MODE_OFF_DELAY: begin
          if (opIn) begin
            curEt  = RST_TIME;
            curRun = 1'b0;
            curQ   = 1'b1;
          end else if (fall) begin
            curApt = ptEff;
            curEt  = RST_TIME;
            curRun = (ptEff != RST_TIME);
            curQ   = (ptEff != RST_TIME);
          end else if (runQ[opCh]) begin
            curEt = etAdv;
            if (etAdv >= curApt) begin
              curRun = 1'b0;
              curQ   = 1'b0;
            end
          end
        end
        MODE_RETENTIVE: begin
          if (opClr) begin
            curEt  = RST_TIME;
            curQ   = 1'b0;
            curRun = 1'b0;
          end else if (opIn) begin
            if (runQ[opCh]) begin
              curEt = etAdv;
            end else begin
              curApt = ptEff;
              curRun = 1'b1;
            end
            if (curEt >= curApt) begin
              curQ = 1'b1;
            end
          end else begin
            if (runQ[opCh]) begin
              curEt = etAdv;
            end
            curRun = 1'b0;
          end
        end
      endcase
      etD[opCh]     = curEt;
      aptD[opCh]    = curApt;
      qD[opCh]      = curQ;
      runD[opCh]    = curRun;
      stampD[opCh]  = msNowQ;
      inPrevD[opCh] = opIn;
      modeD[opCh]   = opMode;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (loadStb && loadCh == CW'(i)) begin
        presetD[i] = loadVal;
      end
      if (clrStb && clrCh == CW'(i)) begin
        etD[i] = RST_TIME;
      end
      if (clrAll) begin
        etD[i]     = RST_TIME;
        qD[i]      = RST_BIT;
        runD[i]    = RST_BIT;
        inPrevD[i] = RST_BIT;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        presetQ[i] <= RST_TIME;
        etQ[i]     <= RST_TIME;
        aptQ[i]    <= RST_TIME;
        stampQ[i]  <= RST_TIME;
        modeQ[i]   <= MODE_PULSE;
      end
      qQ      <= '0;
      runQ    <= '0;
      inPrevQ <= '0;
    end else begin
      presetQ <= presetD;
      etQ     <= etD;
      aptQ    <= aptD;
      stampQ  <= stampD;
      modeQ   <= modeD;
      qQ      <= qD;
      runQ    <= runD;
      inPrevQ <= inPrevD;
    end
  end

  // registered answers and strobe pass-through
  logic              outValidQ;
  logic [CW-1:0]     outChQ;
  logic              qOutQ;
  logic [TIME_W-1:0] etOutQ;
  logic              loadPassQ;
  logic              clrPassQ;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      outValidQ <= 1'b0;
      outChQ    <= '0;
      qOutQ     <= 1'b0;
      etOutQ    <= RST_TIME;
      loadPassQ <= 1'b0;
      clrPassQ  <= 1'b0;
    end else begin
      outValidQ <= opGo;
      outChQ    <= opCh;
      qOutQ     <= opGo & qD[opCh];
      etOutQ    <= opGo ? etD[opCh] : RST_TIME;
      loadPassQ <= loadStb;
      clrPassQ  <= clrStb;
    end
  end

  assign outValid = outValidQ;
  assign outCh    = outChQ;
  assign qOut     = qOutQ;
  assign etOut    = etOutQ;
  assign loadPass = loadPassQ;
  assign clrPass  = clrPassQ;
  assign chDone   = qQ;
  assign msTick   = tickQ;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ret_clear;
    evalValid && evalMode == MODE_RETENTIVE && evalClr && !clrAll;
  endsequence

  sequence s_cleared_answer;
    outValid && !qOut && etOut == 32'h0000_0000;
  endsequence

  a_load_pass_thru: assert property (
    loadPass == $past(loadStb))
    else $error("load strobe not passed through");

  a_clear_pass_thru: assert property (
    ##1 clrPass == $past(clrStb))
    else $error("clear strobe not passed through");

  a_preset_loaded: assert property (
    loadStb |=> presetQ[$past(loadCh)] == $past(loadVal))
    else $error("preset not loaded");

  a_elapsed_cleared: assert property (
    clrStb |=> etQ[$past(clrCh)] == 32'h0000_0000)
    else $error("elapsed not cleared");

  a_elapsed_nonneg: assert property (
    outValid |-> !etOut[TIME_W-1])
    else $error("elapsed time negative");

  a_ret_clear_out: assert property (
    s_ret_clear |=> s_cleared_answer)
    else $error("retentive clear failed");

  a_on_delay_drop: assert property (
    evalValid && evalMode == MODE_ON_DELAY && !evalIn
    |=> outValid && !qOut && etOut == 32'h0000_0000)
    else $error("on-delay not reset by enable low");

  a_off_delay_hold: assert property (
    evalValid && evalMode == MODE_OFF_DELAY && evalIn && !clrAll
    |=> outValid && qOut && etOut == 32'h0000_0000)
    else $error("off-delay not reset by enable high");

  a_idle_chan_hold: assert property (
    !(opGo && opCh == '0) && !(loadStb && loadCh == '0)
    && !(clrStb && clrCh == '0) && !clrAll
    |=> $stable(etQ[0]) && $stable(qQ[0]) && $stable(runQ[0]))
    else $error("idle channel changed state");

  a_clear_all_bits: assert property (
    clrAll |=> qQ == '0 && runQ == '0)
    else $error("clear-all left state behind");

  a_time_base_step: assert property (
    tickQ |=> msNowQ == $past(msNowQ) + 32'h0000_0001)
    else $error("millisecond count did not advance");

endmodule

`default_nettype wire

/* sim/ist_ctl.sv */
// controller model: issues eval, read, load and clear requests
// assumes sys_clk from the bench and eight channels
`timescale 1ns/100ps
`default_nettype none

module ist_ctl
  import ist_pkg::*;
(
  input  wire logic   sys_clk,
  output logic        evalValid,
  output logic [2:0]  evalCh,
  output var ist_mode_t evalMode,
  output logic        evalIn,
  output logic        evalClr,
  output logic        readValid,
  output logic [2:0]  readCh,
  output logic        loadStb,
  output logic [2:0]  loadCh,
  output logic [31:0] loadVal,
  output logic        clrStb,
  output logic [2:0]  clrCh
);
  initial begin
    {evalValid, evalIn, evalClr, readValid, loadStb, clrStb} = '0;
    {evalCh, readCh, loadCh, clrCh, loadVal} = '0;
    evalMode = MODE_PULSE;
  end

  // kind 0 eval, 1 read, 2 load, 3 clear; held for one taken edge
  task automatic req(input int k, input logic [2:0] c, input ist_mode_t m,
                     input logic e, input logic r, input logic [31:0] v);
    @(posedge sys_clk);
    #1;
    {evalCh, readCh, loadCh, clrCh} = {4{c}};
    evalMode = m;
    evalIn = e;
    evalClr = r;
    loadVal = v;
    evalValid = (k == 0);
    readValid = (k == 1);
    loadStb = (k == 2);
    clrStb = (k == 3);
    @(posedge sys_clk);
    #1;
    {evalValid, readValid, loadStb, clrStb} = '0;
  endtask
endmodule

`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the millisecond timer set
// assumes ist_ctl drives requests; tick divider cut to 4 cycles
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import ist_pkg::*;
;
  localparam int TD = 4;
  logic        sys_clk = 0;
  logic        rst_n = 0;
  logic        clrAll = 0;
  logic        evalValid, evalIn, evalClr, readValid, loadStb, clrStb;
  logic [2:0]  evalCh, readCh, loadCh, clrCh, outCh;
  ist_mode_t   evalMode;
  logic [31:0] loadVal, etOut;
  logic        outValid, qOut, loadPass, clrPass, msTick;
  logic [7:0]  chDone;
  logic [7:0]  lf = 8'h35;
  int          fail_count = 0, n_checks = 0, cyc = 0, gap = 0, p, lo, hi;
  bit          seen, pl, pc;
  int          ex[$];

  ist_timer_set #(.NUM_CH(8), .TICK_DIV(TD)) dut (.sys_clk, .rst_n,
    .clrAll, .evalValid, .evalCh, .evalMode, .evalIn, .evalClr,
    .readValid, .readCh, .loadStb, .loadCh, .loadVal, .clrStb, .clrCh,
    .outValid, .outCh, .qOut, .etOut, .loadPass, .clrPass, .chDone,
    .msTick);
  ist_ctl ctl (.sys_clk, .evalValid, .evalCh, .evalMode, .evalIn,
    .evalClr, .readValid, .readCh, .loadStb, .loadCh, .loadVal, .clrStb,
    .clrCh);

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %s exp %0h seen %0h", nm, x, s);
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // eval or read with expected output and elapsed range
  task automatic op(input int k, input logic [2:0] c, input ist_mode_t m,
                    input logic e, input logic r, input int q, input int l,
                    input int h);
    ex.push_back(q);
    ex.push_back(l);
    ex.push_back(h);
    ex.push_back(c);
    ctl.req(k, c, m, e, r, 0);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge msTick);
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
    if (rst_n) begin
      chk("loadPass", loadPass, pl);
      chk("clrPass", clrPass, pc);
      gap++;
      if (msTick) begin
        if (seen)
          chk("tickGap", gap, TD);
        seen = 1;
        gap = 0;
      end
      if (outValid) begin
        chk("qOut", qOut, ex.pop_front());
        lo = ex.pop_front();
        hi = ex.pop_front();
        chk("etOut", etOut >= lo && etOut <= hi, 1);
        chk("outCh", outCh, ex.pop_front());
      end
    end
    pl <= loadStb;
    pc <= clrStb;
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1;
    chk("chDoneRst", chDone, 0);
    ctl.req(2, 2, MODE_PULSE, 0, 0, 5);
    op(0, 2, MODE_ON_DELAY, 1, 0, 0, 0, 0);
    wt(3);
    op(0, 2, MODE_ON_DELAY, 1, 0, 0, 3, 4);
    wt(3);
    op(0, 2, MODE_ON_DELAY, 1, 0, 1, 5, 5);
    @(posedge sys_clk);
    #1 chk("chDone2", chDone[2], 1);
    op(0, 2, MODE_ON_DELAY, 0, 0, 0, 0, 0);
    op(0, 2, MODE_ON_DELAY, 1, 0, 0, 0, 0);
    wt(2);
    op(0, 2, MODE_ON_DELAY, 0, 0, 0, 0, 0);
    op(0, 2, MODE_ON_DELAY, 1, 0, 0, 0, 0);
    ctl.req(2, 2, MODE_PULSE, 0, 0, 1);
    wt(2);
    op(0, 2, MODE_ON_DELAY, 1, 0, 0, 2, 4);
    $display("end onDelay");
    lf = lfsr(lf);
    p = 4 + lf % 3;
    ctl.req(2, 1, MODE_PULSE, 0, 0, p);
    op(0, 1, MODE_PULSE, 1, 0, 1, 0, 0);
    op(0, 1, MODE_PULSE, 0, 0, 1, 0, 1);
    wt(p - 3);
    op(0, 1, MODE_PULSE, 0, 0, 1, p - 3, p - 1);
    wt(3);
    op(0, 1, MODE_PULSE, 0, 0, 0, p, p);
    op(0, 1, MODE_PULSE, 0, 0, 0, 0, 0);
    $display("end pulse");
    ctl.req(2, 3, MODE_PULSE, 0, 0, 4);
    op(0, 3, MODE_OFF_DELAY, 1, 0, 1, 0, 0);
    op(0, 3, MODE_OFF_DELAY, 0, 0, 1, 0, 1);
    wt(1);
    op(0, 3, MODE_OFF_DELAY, 1, 0, 1, 0, 0);
    op(0, 3, MODE_OFF_DELAY, 0, 0, 1, 0, 1);
    wt(5);
    op(0, 3, MODE_OFF_DELAY, 0, 0, 0, 4, 4);
    $display("end offDelay");
    ctl.req(2, 4, MODE_PULSE, 0, 0, 6);
    op(0, 4, MODE_RETENTIVE, 1, 0, 0, 0, 0);
    wt(3);
    op(0, 4, MODE_RETENTIVE, 0, 0, 0, 3, 4);
    wt(4);
    op(1, 4, MODE_PULSE, 0, 0, 0, 3, 4);
    op(0, 4, MODE_RETENTIVE, 1, 0, 0, 3, 5);
    wt(4);
    op(0, 4, MODE_RETENTIVE, 1, 0, 1, 6, 6);
    op(0, 4, MODE_RETENTIVE, 1, 1, 0, 0, 0);
    op(0, 4, MODE_RETENTIVE, 1, 0, 0, 0, 0);
    wt(2);
    op(0, 4, MODE_RETENTIVE, 0, 0, 0, 2, 3);
    ctl.req(3, 4, MODE_PULSE, 0, 0, 0);
    op(1, 4, MODE_PULSE, 0, 0, 0, 0, 0);
    $display("end retentive");
    ctl.req(2, 5, MODE_PULSE, 0, 0, -7);
    op(0, 5, MODE_ON_DELAY, 1, 0, 1, 0, 0);
    @(posedge sys_clk);
    #1 clrAll = 1;
    @(posedge sys_clk);
    #1 clrAll = 0;
    chk("chDoneClr", chDone, 0);
    op(1, 5, MODE_PULSE, 0, 0, 0, 0, 0);
    repeat (3) @(posedge sys_clk);
    $display("end clearAll");
    close_out();
  end
endmodule

`default_nettype wire
